//--- hw/cpmc_pkg.sv
// constants and types for the charge pump mode control block
package cpmc_pkg;
  localparam int ADDR_W = 12;
  localparam int CNT_W = 16;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL = 8'h9a;
  localparam logic [7:0] IDX_ISTAT = 8'ha0;
  localparam logic [7:0] IDX_IMASK = 8'ha1;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = {2'h0, IDX_CTRL, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_ISTAT = {2'h0, IDX_ISTAT, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_IMASK = {2'h0, IDX_IMASK, 2'h0};
  // control register fields
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int THR_BIT = 1;
  localparam int RDY_BIT = 0;
  // interrupt status and mask fields
  localparam int EV_RDY = 0;
  localparam int EV_THR = 1;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // settle time of the pump before it counts as steady
  localparam int CLK_NS = 20;
  localparam int SETTLE_NS = 1000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {
    CPMC_OFF = 2'b00,
    CPMC_GATED = 2'b01,
    CPMC_AUTO = 2'b10,
    CPMC_ON = 2'b11
  } cpmc_mode_t;

  typedef struct packed {
    cpmc_mode_t mode;
    logic above_meta;
    logic above_sync;
    logic above_prev;
    logic pump_on;
    logic [CNT_W-1:0] cnt;
    logic settled;
    logic [1:0] istat;
    logic [1:0] imask;
    logic irq;
    logic awrdy;
    logic aw_full;
    logic [ADDR_W-1:0] awaddr;
    logic wrdy;
    logic w_full;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic arrdy;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } cpmc_state_t;
endpackage

//--- hw/cpmc_top.sv
// charge pump mode control with an axi4-lite register slave
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
// Operation
// RULE1: mode 11 keeps the pump on regardless of supply comparison.
// RULE2: mode 10 runs the pump only while supply is below threshold.
// RULE3: mode 01 runs the pump when converter enabled and supply below threshold.
// RULE4: in mode 01 pump stops when converter disabled or supply above threshold.
// RULE5: mode resets to 00, and writing 00 turns the pump off.
// RULE6: bit 1 reads 1 while supply above threshold, read-only.
// RULE7: bit 0 reads 1 only after pump reached steady state.
// RULE8: mode field sits at bits 7:6, status read-only, all reset zero.
// RULE9: settle counter starts at pump on, clears at pump off, sets ready.
module cpmc_top
  import cpmc_pkg::*;
#(
  parameter int SETTLE_CYCLES = SETTLE_CYC
) (
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  // axi4-lite write data
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // axi4-lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  // axi4-lite read data
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // analog side
  input wire logic SUPPLY_ABOVE_THRESHOLD,
  input wire logic CONVERTER_ENABLE_BIT,
  output logic PUMP_ENABLE,
  // interrupt
  output logic IRQ
);

  // elaboration checks: refuse values the logic cannot serve
  if (SETTLE_CYCLES < 1) begin
    $error("settle count must be at least one cycle");
  end

  if (CNT_W < 1 || CNT_W > 31) begin
    $error("counter width out of range");
  end

  if (SETTLE_CYCLES >= (1 << CNT_W)) begin
    $error("settle count does not fit the counter");
  end

  if (ADDR_W < 10) begin
    $error("address too narrow for the register indices");
  end

  if (ADDR_W > 32) begin
    $error("address wider than the bus allows");
  end

  if (MODE_HI != MODE_LO + 1 || MODE_HI > 7) begin
    $error("mode field must be two adjacent bits of the byte");
  end

  if (THR_BIT >= MODE_LO || RDY_BIT >= MODE_LO || THR_BIT == RDY_BIT) begin
    $error("status bits overlap the mode field or each other");
  end

  if (EV_RDY == EV_THR || EV_RDY > 1 || EV_THR > 1) begin
    $error("event bits must be distinct within the two-bit status");
  end

  if (ADDR_CTRL == ADDR_ISTAT || ADDR_CTRL == ADDR_IMASK || ADDR_ISTAT == ADDR_IMASK) begin
    $error("register addresses must differ");
  end

  if (CTRL_RESET != 8'h00) begin // RULE5 RULE8
    $error("control register must reset to zero");
  end

  if (IRQ_RESET != 2'h0) begin
    $error("interrupt registers must reset to zero");
  end

  if (RESP_OKAY == RESP_SLVERR) begin
    $error("bus responses must differ");
  end

  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYCLES - 1);

  cpmc_state_t s_q;
  cpmc_state_t s_d;

  logic want_on;
  logic do_write;
  logic do_read;
  logic [1:0] ev;
  logic [7:0] ctrl_view;

  // handshake strobes of the channels
  logic aw_take;
  logic w_take;
  logic b_take;
  logic r_take;

  // event detectors feeding the sticky status
  logic rdy_rise;
  logic thr_change;

  // decoded register selects
  logic wr_ctrl;
  logic wr_mask;
  logic wr_err;
  logic [7:0] rd_view;
  logic rd_stat;
  logic rd_err;

  always_comb begin
    s_d = s_q;
    want_on = 1'b0;
    ev = 2'h0;
    // comparator is asynchronous to CLK; the first stage is never read
    s_d.above_meta = SUPPLY_ABOVE_THRESHOLD;
    s_d.above_sync = s_q.above_meta;
    s_d.above_prev = s_q.above_sync;

    // pump request from the mode field; registered before it leaves
    case (s_q.mode)
      CPMC_ON: begin
        want_on = 1'b1; // RULE1
      end
      CPMC_AUTO: begin
        want_on = ~s_q.above_sync; // RULE2
      end
      CPMC_GATED: begin
        // converter bit is on this clock, so it needs no synchroniser
        want_on = CONVERTER_ENABLE_BIT & ~s_q.above_sync; // RULE3 RULE4
      end
      CPMC_OFF: begin
        want_on = 1'b0; // RULE5
      end
      default: begin
        want_on = 1'b0;
      end
    endcase
    s_d.pump_on = want_on;

    // settle counter restarts on every off period
    if (!s_q.pump_on) begin
      s_d.cnt = '0; // RULE9
      s_d.settled = 1'b0; // RULE7
    end else if (s_q.cnt == SETTLE_LAST) begin
      s_d.settled = 1'b1; // RULE7 RULE9
    end else begin
      s_d.cnt = s_q.cnt + CNT_W'(1); // RULE9
    end

    // ready comes from the counter only; the pump reports nothing back
    ctrl_view = 8'h00;
    ctrl_view[MODE_HI:MODE_LO] = s_q.mode; // RULE8
    ctrl_view[THR_BIT] = s_q.above_sync; // RULE6
    ctrl_view[RDY_BIT] = s_q.settled; // RULE7

    // write channel: address and data accepted in either order
    aw_take = s_q.awrdy && S_AXI_AWVALID;
    w_take = s_q.wrdy && S_AXI_WVALID;
    b_take = s_q.bvalid && S_AXI_BREADY;
    if (aw_take) begin
      s_d.aw_full = 1'b1;
      s_d.awaddr = S_AXI_AWADDR;
    end
    if (w_take) begin
      s_d.w_full = 1'b1;
      s_d.wdata = S_AXI_WDATA[7:0];
      s_d.wstrb0 = S_AXI_WSTRB[0];
    end

    // the register changes one edge after both halves are held
    do_write = s_q.aw_full && s_q.w_full && !s_q.bvalid;
    if (do_write) begin
      s_d.aw_full = 1'b0;
      s_d.w_full = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = wr_err ? RESP_SLVERR : RESP_OKAY;
      // a cleared byte strobe leaves the register as it was
      if (wr_ctrl && s_q.wstrb0) begin
        // status bits ignore writes
        s_d.mode = cpmc_mode_t'(s_q.wdata[MODE_HI:MODE_LO]); // RULE5 RULE8
      end
      if (wr_mask && s_q.wstrb0) begin
        s_d.imask = s_q.wdata[1:0];
      end
    end
    if (b_take) begin
      s_d.bvalid = 1'b0;
    end
    // ready drops while a word is held so no second one is taken
    s_d.awrdy = !s_d.aw_full && !s_d.bvalid;
    s_d.wrdy = !s_d.w_full && !s_d.bvalid;

    // read channel: one read at a time
    do_read = s_q.arrdy && S_AXI_ARVALID;
    r_take = s_q.rvalid && S_AXI_RREADY;
    if (do_read) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = rd_err ? RESP_SLVERR : RESP_OKAY;
      s_d.rdata = rd_view;
      // status clears on read; a write to it is ignored
      if (rd_stat) begin
        s_d.istat = 2'h0;
      end
    end
    if (r_take) begin
      s_d.rvalid = 1'b0;
    end
    s_d.arrdy = !s_d.rvalid;

    // events set after the read clear, so a same-cycle event survives
    rdy_rise = s_d.settled & ~s_q.settled;
    thr_change = s_q.above_sync ^ s_q.above_prev;
    ev[EV_RDY] = rdy_rise;
    ev[EV_THR] = thr_change;
    s_d.istat = s_d.istat | ev;
    s_d.irq = |(s_d.istat & s_d.imask);
  end

  // write address decode, taken from the held address
  always_comb begin
    wr_ctrl = 1'b0;
    wr_mask = 1'b0;
    wr_err = 1'b0;
    case (s_q.awaddr)
      ADDR_CTRL: begin
        wr_ctrl = 1'b1;
      end
      ADDR_IMASK: begin
        wr_mask = 1'b1;
      end
      ADDR_ISTAT: begin
        // status clears only by a read
        wr_err = 1'b0;
      end
      default: begin
        wr_err = 1'b1;
      end
    endcase
  end

  // read mux; the address is used at the edge that takes it
  always_comb begin
    rd_view = 8'h00;
    rd_stat = 1'b0;
    rd_err = 1'b0;
    case (S_AXI_ARADDR)
      ADDR_CTRL: begin
        rd_view = ctrl_view; // RULE6 RULE7 RULE8
      end
      ADDR_ISTAT: begin
        rd_view = {6'h00, s_q.istat};
        rd_stat = 1'b1;
      end
      ADDR_IMASK: begin
        rd_view = {6'h00, s_q.imask};
      end
      default: begin
        rd_err = 1'b1;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      s_q <= '0;
      s_q.mode <= cpmc_mode_t'(CTRL_RESET[MODE_HI:MODE_LO]); // RULE5 RULE8
      s_q.istat <= IRQ_RESET;
      s_q.imask <= IRQ_RESET;
      s_q.bresp <= RESP_OKAY;
      s_q.rresp <= RESP_OKAY;
    end else begin
      s_q <= s_d;
    end
  end

  // write channel, straight from the state register
  assign S_AXI_AWREADY = s_q.awrdy;
  assign S_AXI_WREADY = s_q.wrdy;
  assign S_AXI_BVALID = s_q.bvalid;
  assign S_AXI_BRESP = s_q.bresp;

  // read channel; only the low byte carries data
  assign S_AXI_ARREADY = s_q.arrdy;
  assign S_AXI_RVALID = s_q.rvalid;
  assign S_AXI_RRESP = s_q.rresp;
  assign S_AXI_RDATA = {24'h000000, s_q.rdata};

  // analog side and interrupt
  assign PUMP_ENABLE = s_q.pump_on; // RULE1 RULE2 RULE3 RULE4 RULE5
  assign IRQ = s_q.irq;

endmodule

//--- tb/charge_pump_mode_control_tb.sv
// self-checking bench for the charge pump control block
`timescale 1ns/1ps
module charge_pump_mode_control_tb
  import cpmc_pkg::*;
;
  localparam int SET = 4;
  logic CLK = 0, NRST = 0, vdd_low = 1;
  logic [ADDR_W-1:0] S_AXI_AWADDR = '0, S_AXI_ARADDR = '0;
  logic [2:0] S_AXI_AWPROT = 3'h0, S_AXI_ARPROT = 3'h0;
  logic [31:0] S_AXI_WDATA = '0, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB = 4'hf;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
  logic S_AXI_ARVALID = 0, S_AXI_RREADY = 0, CONVERTER_ENABLE_BIT = 0;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic SUPPLY_ABOVE_THRESHOLD, PUMP_ENABLE, IRQ;
  logic [3:0] c;
  int n_fail = 0, checked = 0, cyc = 0;
  cpmc_top #(.SETTLE_CYCLES(SET)) u_cpmc_top (.*);
  cpmc_analog u_cpmc_analog (.vdd_low(vdd_low), .above(SUPPLY_ABOVE_THRESHOLD));
  always #10 CLK = ~CLK;
  // a hung handshake ends here
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      test_done();
    end
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic pump(input logic [1:0] m, input logic low, input logic cv);
    return m == 2'h3 || (m == 2'h2 && low) || (m == 2'h1 && low && cv);
  endfunction
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [1:0] r);
    logic pa, pw, ta, tw;
    pa = 0;
    pw = 0;
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= {24'h0, d};
    S_AXI_AWVALID <= 1;
    S_AXI_WVALID <= 1;
    S_AXI_BREADY <= 1;
    // ready is registered, so its value at the falling edge is what the next rise samples
    while (!(pa && pw)) begin
      @(negedge CLK);
      ta = S_AXI_AWREADY && !pa;
      tw = S_AXI_WREADY && !pw;
      @(posedge CLK);
      if (ta) begin
        pa = 1;
        S_AXI_AWVALID <= 0;
      end
      if (tw) begin
        pw = 1;
        S_AXI_WVALID <= 0;
      end
    end
    do @(negedge CLK); while (!S_AXI_BVALID);
    chk(S_AXI_BRESP, r);
    @(posedge CLK) S_AXI_BREADY <= 0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [1:0] r);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1;
    S_AXI_RREADY <= 1;
    do @(negedge CLK); while (!S_AXI_ARREADY);
    @(posedge CLK) S_AXI_ARVALID <= 0;
    do @(negedge CLK); while (!S_AXI_RVALID);
    chk(S_AXI_RDATA, e);
    chk(S_AXI_RRESP, r);
    @(posedge CLK) S_AXI_RREADY <= 0;
  endtask
  // the output is read at the falling edge, not when the task is called
  task automatic look(input bit pe, input logic e);
    @(negedge CLK) chk(pe ? PUMP_ENABLE : IRQ, e);
    @(posedge CLK);
  endtask
  initial begin
    c = 4'($urandom(97176));
    repeat (20) @(posedge CLK);
    NRST <= 1;
    repeat (2) @(posedge CLK);
    rd(ADDR_CTRL, 32'h0, RESP_OKAY);
    rd(ADDR_ISTAT, 32'h0, RESP_OKAY);
    wr(ADDR_IMASK, 8'h01, RESP_OKAY);
    wr(ADDR_CTRL, 8'hc0, RESP_OKAY);
    repeat (SET + 8) @(posedge CLK);
    look(1'b0, 1'b1);
    rd(ADDR_ISTAT, 32'h1, RESP_OKAY);
    look(1'b0, 1'b0);
    wr(ADDR_IMASK, 8'h00, RESP_OKAY);
    vdd_low <= 0;
    repeat (6) @(posedge CLK);
    look(1'b0, 1'b0);
    wr(ADDR_IMASK, 8'h02, RESP_OKAY);
    rd(ADDR_IMASK, 32'h2, RESP_OKAY);
    repeat (2) @(posedge CLK);
    look(1'b0, 1'b1);
    rd(ADDR_ISTAT, 32'h2, RESP_OKAY);
    rd(ADDR_CTRL, 32'hc3, RESP_OKAY);
    S_AXI_WSTRB <= 4'h0;
    wr(ADDR_CTRL, 8'h00, RESP_OKAY);
    S_AXI_WSTRB <= 4'hf;
    rd(ADDR_CTRL, 32'hc3, RESP_OKAY);
    wr(12'h000, 8'hff, RESP_SLVERR);
    rd(12'h000, 32'h0, RESP_SLVERR);
    $display("done: interrupt and map");
    // all sixteen corners first, then random settings
    for (int i = 0; i < 40; i++) begin
      c = (i < 16) ? i[3:0] : 4'($urandom);
      vdd_low <= c[2];
      CONVERTER_ENABLE_BIT <= c[3];
      wr(ADDR_CTRL, {c[1:0], 6'h3f}, RESP_OKAY);
      repeat (SET + 6) @(posedge CLK);
      look(1'b1, pump(c[1:0], c[2], c[3]));
      rd(ADDR_CTRL, {c[1:0], 4'h0, !c[2], pump(c[1:0], c[2], c[3])}, RESP_OKAY);
    end
    $display("done: mode sweep");
    test_done();
  end
endmodule
bind cpmc_top cpmc_checker u_cpmc_checker (.*);

//--- tb/cpmc_analog.sv
// supply comparator model beside the pump
`timescale 1ns/1ps
module cpmc_analog (
  // supply level set by the bench
  input wire logic vdd_low,
  // comparator output
  output logic above
);
  // no hysteresis: the bench moves the supply in clean steps
  assign above = ~vdd_low;
endmodule

//--- tb/cpmc_checker.sv
// port checker for the charge pump control block
`timescale 1ns/1ps
module cpmc_checker
  import cpmc_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // write side
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // read side
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // analog and interrupt
  input wire logic PUMP_ENABLE,
  input wire logic IRQ
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  property p_bhold;
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rhold;
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_wlat;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID;
  endproperty
  a_wlat: assert property (p_wlat) else $error("write response late");
  property p_rlat;
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read data late");
  property p_wref;
    S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY;
  endproperty
  a_wref: assert property (p_wref) else $error("write taken during response");
  property p_rref;
    S_AXI_RVALID |-> !S_AXI_ARREADY;
  endproperty
  a_rref: assert property (p_rref) else $error("read taken during data");
  property p_rhigh;
    S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0;
  endproperty
  a_rhigh: assert property (p_rhigh) else $error("upper read bits set");
  property p_rres;
    S_AXI_RVALID |-> S_AXI_RDATA[5:2] == 4'h0;
  endproperty
  a_rres: assert property (p_rres) else $error("unused bits read set");
  c_pump: cover property ($rose(PUMP_ENABLE));
  c_irq: cover property ($rose(IRQ));
  c_err: cover property (S_AXI_BVALID && S_AXI_BRESP == RESP_SLVERR);
endmodule
